// ===== hdl/error_log_pkg.sv
// Purpose: Constants, types and record layout of the error history recorder.
// Assumes: 16-bit data words addressed by their data-memory word number.
// Notes:   History words 6569 to 6599 hold a count word and ten 3-word records.
package error_log_pkg;

   localparam int DATA_W    = 16;
   localparam int ADDR_W    = 16;
   localparam int REC_SLOTS = 10;
   localparam int REC_WORDS = 3;
   localparam int CODE_W    = 8;
   localparam int IRQ_W     = 4;

   // Word addresses; the history range and setup words sit at their word numbers.
   localparam logic [ADDR_W-1:0] HIST_FIRST_ADDR   = 16'h19a9;
   localparam logic [ADDR_W-1:0] HIST_LAST_ADDR    = 16'h19c7;
   localparam logic [ADDR_W-1:0] PROTECT_FIRST     = 16'h1800;
   localparam logic [ADDR_W-1:0] PROTECT_LAST      = 16'h19ff;
   localparam logic [ADDR_W-1:0] SCAN_LIMIT_ADDR   = 16'h19da;
   localparam logic [ADDR_W-1:0] LOG_POLICY_ADDR   = 16'h19ff;
   localparam logic [ADDR_W-1:0] CTRL_ADDR         = 16'h0001;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR   = 16'h0002;
   localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR    = 16'h0003;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR   = 16'h0004;
   localparam logic [ADDR_W-1:0] LAST_CODE_ADDR    = 16'h0005;

   // Control word fields.
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int CTRL_FATAL_ACK = 1;

   // Interrupt status bit positions.
   localparam int IRQ_RECORD   = 0;
   localparam int IRQ_FATAL    = 1;
   localparam int IRQ_NONFATAL = 2;
   localparam int IRQ_DROPPED  = 3;

   // Policy field of the setup word and values after reset.
   localparam int                POLICY_LSB        = 0;
   localparam int                POLICY_MSB        = 3;
   localparam logic [3:0]        POLICY_LATEST     = 4'h0;
   localparam logic [3:0]        POLICY_FIRST      = 4'h1;
   localparam logic [DATA_W-1:0] POLICY_WORD_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] SCAN_LIMIT_RESET  = 16'h0064;
   localparam logic [DATA_W-1:0] NO_CLOCK_STAMP    = 16'h0000;

   // Error codes raised by this block.
   localparam logic [CODE_W-1:0] CODE_SLOT1    = 8'hf0;
   localparam logic [CODE_W-1:0] CODE_SLOT2    = 8'hf1;
   localparam logic [CODE_W-1:0] CODE_CABLE    = 8'hff;
   localparam logic [CODE_W-1:0] CODE_IO_OVER  = 8'he1;
   localparam logic [CODE_W-1:0] CODE_SCAN     = 8'h9f;

   // Scan limit unit and clock period; the monitor tick count is derived from them.
   localparam longint SCAN_UNIT_NS    = 1000000;
   localparam longint CLOCK_PERIOD_NS = 50;
   localparam int     SCAN_TICK_CYCLES = int'(SCAN_UNIT_NS / CLOCK_PERIOD_NS);

   typedef enum logic [1:0] {SITE_SLOT1, SITE_SLOT2, SITE_CABLE} fault_site_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_bus_t;

   typedef struct packed {
      logic              alarm_valid;
      logic [CODE_W-1:0] alarm_num;
      logic              nonfatal_valid;
      logic [CODE_W-1:0] nonfatal_code;
      logic              bus_fault;
      fault_site_t       site;
      logic              io_over;
      logic              scan_end;
   } error_in_t;

   typedef logic [REC_SLOTS-1:0][REC_WORDS-1:0][DATA_W-1:0] record_mem_t;

   typedef struct packed {
      logic [DATA_W-1:0] policy_word;
      logic [DATA_W-1:0] scan_limit;
      logic              clear;
      logic [3:0]        count;
      record_mem_t       rec;
      logic [IRQ_W-1:0]  status;
      logic [IRQ_W-1:0]  enable;
      logic [CODE_W-1:0] last_code;
      logic              fatal;
      logic              irq;
      logic [DATA_W-1:0] rdata;
      logic [15:0]       tick_cnt;
      logic [DATA_W-1:0] scan_units;
      logic              scan_tripped;
   } state_t;

endpackage

// ===== hdl/error_log_recorder.sv
// Purpose: Records fatal and non-fatal error codes with a time stamp in a ten-slot history.
// Assumes: All inputs synchronous to clock; ce low freezes every flip-flop.
// Notes:   One record is taken per cycle; lower-priority events in the same cycle are lost, save a scan overrun, which retries next cycle.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Log every error code with its time stamp
// - History lives in words 6569 to 6599
// - Recording ignores the setup write-protect switch
// - Policy from bits 00-03 of setup word
// - Policy 0: keep latest ten, shift oldest out
// - Policy 1: keep first ten, drop later ones
// - Policy 2 to F: store nothing
// - Disabled log leaves range as read-only words
// - Policy resets to zero, keep latest
// - No clock fitted: stamp reads 0000
// - Clear bit set erases all records
// - Clear bit returns to zero by itself
// - Severe alarm raises fatal code 01-99
// - Scan over limit raises fatal code 9F
// - Bus faults give F0, F1 or FF
// - Too many I/O words gives fatal E1
// - Non-fatal error keeps program running
module error_log_recorder
#(
   parameter int TICK_CYCLES = error_log_pkg::SCAN_TICK_CYCLES
) (
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   input  wire logic                          ce,
   input  wire error_log_pkg::reg_bus_t       bus,
   output logic [error_log_pkg::DATA_W-1:0]   rdata,
   input  wire error_log_pkg::error_in_t      err,
   input  wire logic                          protect_sw,
   input  wire logic                          rtc_present,
   input  wire logic [31:0]                   rtc_stamp,
   output logic                               fatal_halt,
   output logic                               irq
);
   import error_log_pkg::*;

   state_t st_r;
   state_t st_nxt;

   logic              ev_valid;
   logic              scan_over;
   logic [CODE_W-1:0] ev_code;
   logic              ev_fatal;
   logic [3:0]        policy;
   logic [DATA_W-1:0] stamp_hi;
   logic [DATA_W-1:0] stamp_lo;
   logic              tick;

   function automatic logic is_alarm_num(input logic [CODE_W-1:0] n);
      return (n[7:4] <= 4'h9) && (n[3:0] <= 4'h9) && (n != 8'h00);
   endfunction

   function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] lo,
                                     input logic [ADDR_W-1:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [DATA_W-1:0] hist_word(input state_t s,
                                                   input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] idx;
      logic [ADDR_W-1:0] slot;
      logic [ADDR_W-1:0] word;
      idx  = a - HIST_FIRST_ADDR;
      slot = (idx - 16'h0001) / 16'h0003;
      word = (idx - 16'h0001) % 16'h0003;
      if (idx == 16'h0000) begin
         return {12'h000, s.count};
      end
      return s.rec[slot[3:0]][word[1:0]];
   endfunction

   assign policy   = st_r.policy_word[POLICY_MSB:POLICY_LSB];
   assign tick     = (st_r.tick_cnt == 16'(TICK_CYCLES - 1));
   assign stamp_hi = rtc_present ? rtc_stamp[31:16] : NO_CLOCK_STAMP;
   assign stamp_lo = rtc_present ? rtc_stamp[15:0]  : NO_CLOCK_STAMP;

   // The overrun alarm fires once per scan; a non-fatal code that happens to read 9F must
   // not disarm it, so the arm flag follows this condition and not the recorded code.
   assign scan_over = (st_r.scan_units > st_r.scan_limit) && !st_r.scan_tripped
                      && !err.scan_end;

   // Error sources, most serious first.
   always_comb begin
      ev_valid = 1'b1;
      ev_fatal = 1'b1;
      ev_code  = 8'h00;
      if (err.bus_fault) begin
         unique case (err.site)
            SITE_SLOT1: ev_code = CODE_SLOT1;
            SITE_SLOT2: ev_code = CODE_SLOT2;
            default:    ev_code = CODE_CABLE;
         endcase
      end else if (err.io_over) begin
         ev_code = CODE_IO_OVER;
      end else if (scan_over) begin
         ev_code = CODE_SCAN;
      end else if (err.alarm_valid && is_alarm_num(err.alarm_num)) begin
         ev_code = err.alarm_num;
      end else if (err.nonfatal_valid) begin
         ev_code  = err.nonfatal_code;
         ev_fatal = 1'b0;
      end else begin
         ev_valid = 1'b0;
         ev_fatal = 1'b0;
      end
   end

   always_comb begin
      logic [IRQ_W-1:0] set_bits;
      logic             stored;
      set_bits = '0;
      stored   = 1'b0;
      st_nxt   = st_r;
      st_nxt.rdata = '0;

      st_nxt.tick_cnt = tick ? 16'h0000 : st_r.tick_cnt + 16'h0001;
      if (err.scan_end) begin
         st_nxt.scan_units   = '0;
         st_nxt.scan_tripped = 1'b0;
      end else if (tick && st_r.scan_units != 16'hffff) begin
         st_nxt.scan_units = st_r.scan_units + 16'h0001;
      end
      if (scan_over && !err.bus_fault && !err.io_over) begin
         st_nxt.scan_tripped = 1'b1;
      end

      // Erase runs first so a record in the same cycle lands in a fresh log.
      if (st_r.clear) begin
         st_nxt.rec   = '0;
         st_nxt.count = 4'h0;
         st_nxt.clear = 1'b0;
      end

      if (ev_valid) begin
         st_nxt.last_code = ev_code;
         set_bits[ev_fatal ? IRQ_FATAL : IRQ_NONFATAL] = 1'b1;
         if (ev_fatal) begin
            st_nxt.fatal = 1'b1;
         end
         // Recording never looks at the setup write-protect switch.
         if (policy == POLICY_LATEST || policy == POLICY_FIRST) begin
            if (st_nxt.count < 4'(REC_SLOTS)) begin
               st_nxt.rec[st_nxt.count] = {stamp_lo, stamp_hi, 8'h00, ev_code};
               st_nxt.count = st_nxt.count + 4'h1;
               stored = 1'b1;
            end else if (policy == POLICY_LATEST) begin
               for (int i = 0; i < REC_SLOTS - 1; i++) begin
                  st_nxt.rec[i] = st_nxt.rec[i + 1];
               end
               st_nxt.rec[REC_SLOTS-1] = {stamp_lo, stamp_hi, 8'h00, ev_code};
               stored = 1'b1;
            end else begin
               set_bits[IRQ_DROPPED] = 1'b1;
            end
         end
         set_bits[IRQ_RECORD] = stored;
      end

      if (bus.wr) begin
         if (bus.addr == LOG_POLICY_ADDR && !protect_sw) begin
            st_nxt.policy_word = bus.wdata;
         end
         if (bus.addr == SCAN_LIMIT_ADDR && !protect_sw) begin
            st_nxt.scan_limit = bus.wdata;
         end
         if (bus.addr == CTRL_ADDR) begin
            if (bus.wdata[CTRL_CLEAR_BIT]) begin
               st_nxt.clear = 1'b1;
            end
            if (bus.wdata[CTRL_FATAL_ACK] && !(ev_valid && ev_fatal)) begin
               st_nxt.fatal = 1'b0;
            end
         end
         if (bus.addr == IRQ_CLEAR_ADDR) begin
            st_nxt.status = st_r.status & ~bus.wdata[IRQ_W-1:0];
         end
         if (bus.addr == IRQ_ENABLE_ADDR) begin
            st_nxt.enable = bus.wdata[IRQ_W-1:0];
         end
      end
      // A new event wins over a clear in the same cycle.
      st_nxt.status = st_nxt.status | set_bits;
      st_nxt.irq    = |(st_nxt.status & st_nxt.enable);

      // The history range accepts no writes and reads back at any policy.
      if (bus.rd) begin
         if (in_range(bus.addr, HIST_FIRST_ADDR, HIST_LAST_ADDR)) begin
            st_nxt.rdata = hist_word(st_r, bus.addr);
         end else if (bus.addr == LOG_POLICY_ADDR) begin
            st_nxt.rdata = st_r.policy_word;
         end else if (bus.addr == SCAN_LIMIT_ADDR) begin
            st_nxt.rdata = st_r.scan_limit;
         end else if (bus.addr == CTRL_ADDR) begin
            st_nxt.rdata = {14'h0000, st_r.fatal, st_r.clear};
         end else if (bus.addr == IRQ_STATUS_ADDR) begin
            st_nxt.rdata = {12'h000, st_r.status};
         end else if (bus.addr == IRQ_ENABLE_ADDR) begin
            st_nxt.rdata = {12'h000, st_r.enable};
         end else if (bus.addr == LAST_CODE_ADDR) begin
            st_nxt.rdata = {8'h00, st_r.last_code};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r              <= '0;
         st_r.policy_word  <= POLICY_WORD_RESET;
         st_r.scan_limit   <= SCAN_LIMIT_RESET;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign rdata      = st_r.rdata;
   assign fatal_halt = st_r.fatal;
   assign irq        = st_r.irq;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_clear_req;
      ce && bus.wr && bus.addr == CTRL_ADDR && bus.wdata[CTRL_CLEAR_BIT];
   endsequence

   sequence s_erase_done;
      ce && st_r.clear ##1 st_r.count == 4'h0 && !st_r.clear;
   endsequence

   // An event in the erasing cycle lands in the fresh log, so such cycles are left out here.
   a_clear_erases: assert property (s_clear_req ##1 (ce && !ev_valid && !bus.wr)
                                    |-> s_erase_done)
      else $error("history not erased after clear request");

   a_clear_self_off: assert property (s_clear_req ##1 (ce && !bus.wr) |=> !st_r.clear)
      else $error("clear bit did not return to zero");

   a_store_latest: assert property (ce && ev_valid && policy == POLICY_LATEST && !st_r.clear
                                    && st_r.count == 4'(REC_SLOTS)
                                    |=> st_r.rec[REC_SLOTS-1][0][7:0] == $past(ev_code)
                                        && st_r.rec[0] == $past(st_r.rec[1]))
      else $error("latest policy did not shift in new record");

   a_keep_first: assert property (ce && ev_valid && policy == POLICY_FIRST && !st_r.clear
                                  && st_r.count == 4'(REC_SLOTS) |=> $stable(st_r.rec))
      else $error("first-ten policy changed stored records");

   a_disabled_log: assert property (ce && policy > POLICY_FIRST && !st_r.clear
                                    |=> $stable(st_r.rec) && $stable(st_r.count))
      else $error("records stored while log disabled");

   a_first_free: assert property (ce && ev_valid && policy <= POLICY_FIRST && !st_r.clear
                                  && st_r.count < 4'(REC_SLOTS)
                                  |=> st_r.count == $past(st_r.count) + 4'h1)
      else $error("record not placed in next free slot");

   a_protect_log: assert property (ce && ev_valid && protect_sw && policy == POLICY_LATEST
                                   && !st_r.clear |=> st_r.status[IRQ_RECORD])
      else $error("write protect blocked recording");

   a_no_clock_stamp: assert property (ce && ev_valid && !rtc_present && !st_r.clear
                                      && policy == POLICY_LATEST && st_r.count == 4'h0
                                      |=> st_r.rec[0][1] == NO_CLOCK_STAMP
                                          && st_r.rec[0][2] == NO_CLOCK_STAMP)
      else $error("stamp not zero without clock");

   a_scan_code: assert property (ce && ev_valid && ev_fatal && ev_code == CODE_SCAN
                                 |=> st_r.fatal && st_r.last_code == CODE_SCAN)
      else $error("scan overrun did not raise fatal 9F");

   a_slot_codes: assert property (ce && err.bus_fault |=> st_r.fatal
                                  && st_r.last_code[7:4] == 4'hf)
      else $error("bus fault code wrong");

   a_io_over: assert property (ce && !err.bus_fault && err.io_over |=> st_r.fatal
                               && st_r.last_code == CODE_IO_OVER)
      else $error("io overflow did not give E1");

   a_alarm_code: assert property (ce && ev_valid && ev_fatal && ev_code == err.alarm_num
                                  && err.alarm_valid |=> st_r.last_code == $past(err.alarm_num))
      else $error("severe alarm code not recorded");

   a_nonfatal_run: assert property (ce && ev_valid && !ev_fatal && !st_r.fatal |=> !st_r.fatal)
      else $error("non-fatal error halted program");

   a_policy_reset: assert property ($rose(rst_n) |-> policy == POLICY_LATEST)
      else $error("policy not zero after reset");

   a_rdata_idle: assert property (ce && !bus.rd |=> rdata == 16'h0000)
      else $error("read data not zero outside a read");

   a_hist_read_only: assert property (ce && bus.wr && !ev_valid && !st_r.clear
                                      && in_range(bus.addr, HIST_FIRST_ADDR, HIST_LAST_ADDR)
                                      |=> $stable(st_r.rec) && $stable(st_r.count))
      else $error("history changed by a bus write");

   a_setup_protect: assert property (ce && bus.wr && protect_sw
                                     |=> $stable(st_r.policy_word) && $stable(st_r.scan_limit))
      else $error("protected setup word was written");

   a_irq_level: assert property (irq == |(st_r.status & st_r.enable))
      else $error("interrupt does not follow status and enable");

   a_scan_once: assert property (st_r.scan_tripped && !err.scan_end
                                 |-> !(ev_valid && ev_fatal && ev_code == CODE_SCAN))
      else $error("second overrun alarm in one scan");

   a_count_bound: assert property (st_r.count <= 4'(REC_SLOTS))
      else $error("record count beyond ten");

   a_record_word0: assert property (ce && ev_valid && policy <= POLICY_FIRST && !st_r.clear
                                    && st_r.count < 4'(REC_SLOTS)
                                    |=> st_r.rec[$past(st_r.count)][0] == {8'h00, $past(ev_code)})
      else $error("code word of new record wrong");

   a_stamp_words: assert property (ce && ev_valid && rtc_present && !st_r.clear
                                   && policy <= POLICY_FIRST && st_r.count < 4'(REC_SLOTS)
                                   |=> st_r.rec[$past(st_r.count)][1] == $past(rtc_stamp[31:16])
                                       && st_r.rec[$past(st_r.count)][2] == $past(rtc_stamp[15:0]))
      else $error("time stamp of new record wrong");

   a_nonfatal_status: assert property (ce && ev_valid && !ev_fatal
                                       |=> st_r.status[IRQ_NONFATAL])
      else $error("non-fatal error not reported");

   a_fatal_hold: assert property (ce && st_r.fatal
                                  && !(bus.wr && bus.addr == CTRL_ADDR && bus.wdata[CTRL_FATAL_ACK])
                                  |=> st_r.fatal)
      else $error("fatal halt dropped without acknowledge");

endmodule // error_log_recorder

`default_nettype wire

// ===== testbench/tb.sv
// Purpose: Self-checking bench for the error history recorder, driven through its word bus.
// Assumes: TICK_CYCLES is cut to 4 so that a scan overrun trips within a few cycles.
// Notes:   The scan limit is raised to its maximum first, so no overrun lands in other tests.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import error_log_pkg::*;
   localparam int TICKS = 4;
   localparam int CEILING = 6000;
   logic              clock;
   logic              rst_n;
   logic              ce;
   reg_bus_t          bus;
   logic [DATA_W-1:0] rdata;
   error_in_t         err;
   logic              protect_sw;
   logic              rtc_present;
   logic [31:0]       rtc_stamp;
   logic              fatal_halt;
   logic              irq;
   int                fails;
   int                compares;
   int                cycles;
   int                n;
   logic [DATA_W-1:0] got;
   error_in_t         e;
   logic [CODE_W-1:0] codes [5] = '{CODE_SLOT1, CODE_SLOT2, CODE_CABLE, CODE_CABLE, 8'h42};

   error_log_recorder #(.TICK_CYCLES(TICKS)) dut (
      .clock       (clock),
      .rst_n       (rst_n),
      .ce          (ce),
      .bus         (bus),
      .rdata       (rdata),
      .err         (err),
      .protect_sw  (protect_sw),
      .rtc_present (rtc_present),
      .rtc_stamp   (rtc_stamp),
      .fatal_halt  (fatal_halt),
      .irq         (irq)
   );

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles >= CEILING) begin
         fails++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("Counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk_word(input string name, input logic [DATA_W-1:0] exp,
                           input logic [DATA_W-1:0] seen);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic seen);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %b seen %b", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                         input string name);
      rd(a, got);
      chk_word(name, exp, got);
   endtask

   task automatic pulse(input error_in_t ev);
      @(posedge clock);
      err <= ev;
      @(posedge clock);
      err <= '0;
   endtask

   function automatic error_in_t nf(input logic [CODE_W-1:0] c);
      error_in_t v;
      v = '0;
      v.nonfatal_valid = 1'b1;
      v.nonfatal_code = c;
      return v;
   endfunction

   function automatic logic [ADDR_W-1:0] rec_addr(input int k, input int w);
      return HIST_FIRST_ADDR + ADDR_W'(1 + 3 * k + w);
   endfunction

   // Clearing the log is a two-step affair, so the bit is read back well after it settles.
   task automatic clear_log();
      wr(CTRL_ADDR, 16'h0001);
      rd_chk(HIST_FIRST_ADDR, 16'h0000, "count_after_clear");
      rd_chk(rec_addr(0, 0), 16'h0000, "record_after_clear");
      rd(CTRL_ADDR, got);
      chk_bit("clear_bit", 1'b0, got[CTRL_CLEAR_BIT]);
   endtask

   initial begin
      fails = 0;
      compares = 0;
      cycles = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      bus = '0;
      err = '0;
      protect_sw = 1'b0;
      rtc_present = 1'b1;
      rtc_stamp = 32'h2406_1530;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      rd_chk(LOG_POLICY_ADDR, 16'h0000, "policy_reset");
      rd_chk(SCAN_LIMIT_ADDR, 16'h0064, "scan_limit_reset");
      rd_chk(HIST_FIRST_ADDR, 16'h0000, "count_reset");
      chk_bit("fatal_reset", 1'b0, fatal_halt);
      wr(SCAN_LIMIT_ADDR, 16'hffff);
      $display("Test reset done");

      wr(IRQ_ENABLE_ADDR, 16'h0001);
      e = '0;
      e.io_over = 1'b1;
      pulse(e);
      rd_chk(HIST_FIRST_ADDR, 16'h0001, "count_one");
      rd_chk(rec_addr(0, 0), 16'h00e1, "io_over_code");
      rd_chk(rec_addr(0, 1), 16'h2406, "stamp_high");
      rd_chk(rec_addr(0, 2), 16'h1530, "stamp_low");
      chk_bit("fatal_set", 1'b1, fatal_halt);
      chk_bit("irq_raised", 1'b1, irq);
      wr(IRQ_CLEAR_ADDR, 16'h000f);
      #1;
      chk_bit("irq_cleared", 1'b0, irq);
      wr(IRQ_ENABLE_ADDR, 16'h0000);
      wr(CTRL_ADDR, 16'h0002);
      pulse(nf(8'h33));
      #1;
      chk_bit("irq_masked", 1'b0, irq);
      chk_bit("nonfatal_runs", 1'b0, fatal_halt);
      rd_chk(rec_addr(1, 0), 16'h0033, "nonfatal_code");
      $display("Test single record done");

      protect_sw <= 1'b1;
      wr(LOG_POLICY_ADDR, 16'h0002);
      rd_chk(LOG_POLICY_ADDR, 16'h0000, "policy_protected");
      for (int i = 0; i < 5; i++) begin
         e = '0;
         if (i < 4) begin
            e.bus_fault = 1'b1;
            e.site = fault_site_t'(i);
         end else begin
            e.alarm_valid = 1'b1;
            e.alarm_num = 8'h42;
         end
         rtc_present <= (i < 4);
         pulse(e);
         rd_chk(LAST_CODE_ADDR, {8'h00, codes[i]}, "last_code");
         rd_chk(rec_addr(2 + i, 0), {8'h00, codes[i]}, "record_code");
      end
      rd_chk(rec_addr(6, 1), NO_CLOCK_STAMP, "no_clock_stamp");
      rd_chk(rec_addr(6, 2), NO_CLOCK_STAMP, "no_clock_stamp");
      protect_sw <= 1'b0;
      rtc_present <= 1'b1;
      $display("Test error codes done");

      wr(LOG_POLICY_ADDR, 16'hfff0);
      for (int i = 0; i < 4; i++) begin
         pulse(nf(8'h50 + CODE_W'(i)));
      end
      rd_chk(HIST_FIRST_ADDR, 16'h000a, "count_full");
      rd_chk(rec_addr(0, 0), 16'h0033, "oldest_shifted");
      rd_chk(rec_addr(8, 0), 16'h0052, "shifted_entry");
      rd_chk(rec_addr(9, 0), 16'h0053, "newest_entry");
      clear_log();
      $display("Test keep latest done");

      wr(LOG_POLICY_ADDR, 16'h0001);
      for (int i = 0; i < 11; i++) begin
         pulse(nf(8'h60 + CODE_W'(i)));
      end
      rd_chk(HIST_FIRST_ADDR, 16'h000a, "count_first");
      rd_chk(rec_addr(0, 0), 16'h0060, "first_kept");
      rd_chk(rec_addr(9, 0), 16'h0069, "tenth_kept");
      rd(IRQ_STATUS_ADDR, got);
      chk_bit("dropped_flag", 1'b1, got[IRQ_DROPPED]);
      clear_log();
      $display("Test keep first done");

      wr(LOG_POLICY_ADDR, 16'h0007);
      pulse(nf(8'h70));
      rd_chk(HIST_FIRST_ADDR, 16'h0000, "count_disabled");
      rd_chk(rec_addr(0, 0), 16'h0000, "record_disabled");
      wr(rec_addr(0, 0), 16'hbeef);
      rd_chk(rec_addr(0, 0), 16'h0000, "history_read_only");
      $display("Test disabled done");

      wr(LOG_POLICY_ADDR, 16'h0000);
      e = '0;
      e.scan_end = 1'b1;
      // The monitor has been counting since reset, so it restarts before the limit drops.
      pulse(e);
      wr(SCAN_LIMIT_ADDR, 16'h0002);
      wr(CTRL_ADDR, 16'h0002);
      rtc_present <= 1'b0;
      pulse(e);
      n = 0;
      #1;
      while (fatal_halt !== 1'b1 && n < 100) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk_bit("overrun_time", 1'b1, n >= 2 * TICKS + 2 && n <= 3 * TICKS + 1);
      rd_chk(LAST_CODE_ADDR, 16'h009f, "overrun_code");
      rd_chk(rec_addr(0, 0), 16'h009f, "overrun_record");
      rd_chk(rec_addr(0, 1), NO_CLOCK_STAMP, "overrun_stamp");
      ce <= 1'b0;
      pulse(nf(8'h77));
      ce <= 1'b1;
      rd_chk(HIST_FIRST_ADDR, 16'h0001, "count_frozen");
      $display("Test scan overrun done");
      stop_test();
   end
endmodule // tb
`default_nettype wire
